// [tb_umh.sv]
/* self-checking bench for the modem handshake block.
   assumes: apb master tasks below; the modem model drives the status pins. */
`timescale 1ns/1ps
`include "umh_map.vh"
module tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire        pready, pslverr, dtrN, rtsN, loopbackMode, irq;
  wire [3:0]  pins;
  reg  [31:0] rd;
  reg         er;
  integer     err_count = 0, check_count = 0, i;
  // 4 ns period
  always #2 clk = ~clk;
  umh_modem_model mdm (.clk(clk), .pins(pins));
  umh_modem_ctl uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clear_to_send_n(pins[0]), .data_set_ready_n(pins[1]),
    .ring_indicator_n(pins[2]), .carrier_detect_n(pins[3]), .terminal_ready_n(dtrN),
    .request_to_send_n(rtsN), .loopbackMode(loopbackMode), .irq(irq));
  task results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [63:0] what, input [31:0] exp, input [31:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("mismatch %0s exp %h got %h", what, exp, got);
    end
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) begin
      err_count = err_count + 1;
      results;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdk(input [11:0] a, input [31:0] exp, input [63:0] what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk("dtr", 32'h1, {31'h0, dtrN});
    chk("rts", 32'h1, {31'h0, rtsN});
    rdk(`UMH_OFS_MSR, 32'h0, "msr");
    rdk(`UMH_OFS_MCR, 32'h0, "mcr");
    rdk(`UMH_OFS_IER, 32'h0, "ier");
    rdk(`UMH_OFS_IMASK, 32'h0, "imask");
    rdk(12'h020, 32'h0, "unmap");
    chk("slverr", 32'h1, {31'h0, er});
    $display("test reset done");
    // every dtr/rts code, then loopback with both bits set
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, `UMH_OFS_MCR, i);
      repeat (2) @(posedge clk);
      chk("dtr", {31'h0, ~i[0]}, {31'h0, dtrN});
      chk("rts", {31'h0, ~i[1]}, {31'h0, rtsN});
    end
    apb(1'b1, `UMH_OFS_MCR, 32'h13);
    repeat (2) @(posedge clk);
    chk("dtr", 32'h1, {31'h0, dtrN});
    chk("rts", 32'h1, {31'h0, rtsN});
    chk("loop", 32'h1, {31'h0, loopbackMode});
    rdk(`UMH_OFS_MCR, 32'h13, "mcr");
    $display("test control done");
    // each pin falls and rises; flags clear on read, irq until w1c
    apb(1'b1, `UMH_OFS_IER, 32'h8);
    apb(1'b1, `UMH_OFS_IMASK, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      mdm.setPins(4'hf ^ (4'h1 << i));
      repeat (6) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      rdk(`UMH_OFS_MSR, 32'h11 << i, "msr");
      rdk(`UMH_OFS_MSR, 32'h10 << i, "msr");
      mdm.setPins(4'hf);
      repeat (6) @(posedge clk);
      rdk(`UMH_OFS_MSR, 32'h1 << i, "msr");
      apb(1'b1, `UMH_OFS_ISTAT, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
    end
    $display("test pins done");
    // masked event: status sticks, output stays low
    apb(1'b1, `UMH_OFS_IMASK, 32'h0);
    mdm.setPins(4'he);
    repeat (6) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rdk(`UMH_OFS_ISTAT, 32'h1, "istat");
    rdk(`UMH_OFS_MSR, 32'h11, "msr");
    apb(1'b1, `UMH_OFS_ISTAT, 32'h1);
    rdk(`UMH_OFS_ISTAT, 32'h0, "istat");
    $display("test mask done");
    // reset in mid-run with both outputs active
    apb(1'b1, `UMH_OFS_MCR, 32'h3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("dtr", 32'h1, {31'h0, dtrN});
    chk("rts", 32'h1, {31'h0, rtsN});
    $display("test rerun done");
    results;
  end
endmodule

// [umh_map.vh]
/*
  umh_map.vh: register offsets, bit positions and reset values for the
  modem handshake block.
  assumes: included by the design files by bare name; 32-bit apb data.
*/
`ifndef UMH_MAP_VH
`define UMH_MAP_VH

// register byte offsets on apb
`define UMH_OFS_IER      12'h000
`define UMH_OFS_MCR      12'h004
`define UMH_OFS_MSR      12'h008
`define UMH_OFS_ISTAT    12'h00C
`define UMH_OFS_IMASK    12'h010

// interrupt enable register
`define UMH_IER_MODEM    3

// modem control register
`define UMH_MCR_DTR      0
`define UMH_MCR_RTS      1
`define UMH_MCR_LOOP     4
`define UMH_MCR_W        5

// modem status register
`define UMH_MSR_DCTS     0
`define UMH_MSR_DDSR     1
`define UMH_MSR_DRI      2
`define UMH_MSR_DDCD     3
`define UMH_MSR_CTS      4
`define UMH_MSR_DSR      5
`define UMH_MSR_RI       6
`define UMH_MSR_DCD      7

// sticky event status bits
`define UMH_EV_MODEM     0
`define UMH_EV_W         1

// reset values
`define UMH_RST_IER      8'h00
`define UMH_RST_MCR      5'h00
`define UMH_RST_MASK     1'h0

`endif

// [umh_modem_ctl.v]
/*
  umh_modem_ctl.v: modem handshake section of a serial port. senses four
  active-low modem inputs, reports levels and changes in the modem status
  register, raises an interrupt on change, drives terminal ready and
  request to send from the modem control register.
  assumes: apb master on clk; modem pins asynchronous to clk; the
  transmitter lives elsewhere and never sees clear to send.
*/
// Decided for this implementation: register access over APB and the address map.
// Summary of operation
// - status bit 4 reads the inverse of the clear-to-send pin
// - status bit 5 reads the inverse of the data-set-ready pin
// - status bit 6 reads the inverse of the ring-indicator pin
// - status bit 7 reads the inverse of the carrier-detect pin
// - status bit 0 sets when clear-to-send changed since last status read
// - status bit 1 sets when data-set-ready changed since last status read
// - status bit 2 sets when ring-indicator changed since last status read
// - status bit 3 sets when carrier-detect changed since last status read
// - with enable bit 3 and interrupt mask bit 0 set, any modem input change raises an interrupt
// - clear-to-send never gates or alters the transmitter
// - terminal-ready output low when control bit 0 is one
// - request-to-send output low when control bit 1 is one
// - reset drives request-to-send high
// - loopback holds request-to-send inactive regardless of its bit
// - reset and loopback hold terminal-ready inactive
`timescale 1ns/1ps
`include "umh_map.vh"
module umh_modem_ctl #(
  parameter AW = 12
) (
  input  wire          clk,                // system clock, 250 MHz
  input  wire          rst,                // synchronous reset, active high
  input  wire          psel,               // apb select
  input  wire          penable,            // apb access phase
  input  wire          pwrite,             // apb write
  input  wire [AW-1:0] paddr,              // apb byte address
  input  wire [31:0]   pwdata,             // apb write data
  input  wire [3:0]    pstrb,              // apb byte strobes
  output reg  [31:0]   prdata,             // apb read data
  output reg           pready,             // apb ready
  output reg           pslverr,            // apb error on unmapped address
  input  wire          clear_to_send_n,    // modem clear to send, low active
  input  wire          data_set_ready_n,   // modem data set ready, low active
  input  wire          ring_indicator_n,   // modem ring indicator, low active
  input  wire          carrier_detect_n,   // modem carrier detect, low active
  output reg           terminal_ready_n,   // terminal ready, low active
  output reg           request_to_send_n,  // request to send, low active
  output reg           loopbackMode,       // loopback select to the data path
  output reg           irq                 // level interrupt
);

  // address classes returned by the decoder
  localparam [2:0] SEL_NONE  = 3'd0;
  localparam [2:0] SEL_IER   = 3'd1;
  localparam [2:0] SEL_MCR   = 3'd2;
  localparam [2:0] SEL_MSR   = 3'd3;
  localparam [2:0] SEL_ISTAT = 3'd4;
  localparam [2:0] SEL_IMASK = 3'd5;

  // decode a byte address; used for both read and write paths
  function [2:0] decode;
    input [AW-1:0] a;
    begin
      if (a == `UMH_OFS_IER)
        decode = SEL_IER;
      else if (a == `UMH_OFS_MCR)
        decode = SEL_MCR;
      else if (a == `UMH_OFS_MSR)
        decode = SEL_MSR;
      else if (a == `UMH_OFS_ISTAT)
        decode = SEL_ISTAT;
      else if (a == `UMH_OFS_IMASK)
        decode = SEL_IMASK;
      else
        decode = SEL_NONE;
    end
  endfunction

  // pin order inside vectors: 0 cts, 1 dsr, 2 ri, 3 dcd
  wire [3:0] pinRaw = {carrier_detect_n, ring_indicator_n,
                       data_set_ready_n, clear_to_send_n};
  wire [3:0] pinSync;
  reg  [3:0] pinPrev_q;
  reg  [3:0] delta_q;
  reg  [7:0] ier_q;
  reg  [4:0] mcr_q;
  reg  [`UMH_EV_W-1:0] evStat_q;
  reg  [`UMH_EV_W-1:0] evMask_q;

  umh_sync2 #(
    .WIDTH   (4),
    .RST_VAL (4'hF)
  ) u_sync (
    .clk   (clk),
    .rst   (rst),
    .async (pinRaw),
    .syncQ (pinSync)
  );

  // access phase; single-cycle answer so pready is high on each access
  wire       access   = psel & penable;
  wire [2:0] sel      = decode(paddr);
  wire       wrLo     = access & pwrite & pstrb[0];
  wire       msrRead  = access & ~pwrite & (sel == SEL_MSR);
  wire [3:0] pinEdge  = pinSync ^ pinPrev_q;
  // complement of each pin forms the upper status nibble
  wire [3:0] levels   = ~pinSync;
  wire [7:0] msrValue = {levels, delta_q};
  wire       modemInt = ier_q[`UMH_IER_MODEM] & (|delta_q);

  // previous synchronised level, for change detection
  always @(posedge clk) begin
    if (rst)
      pinPrev_q <= 4'hF;
    else
      pinPrev_q <= pinSync;
  end

  // change flags: any toggle sets, status read clears, set beats clear
  always @(posedge clk) begin
    if (rst)
      delta_q <= 4'h0;
    else if (msrRead)
      delta_q <= pinEdge;
    else
      delta_q <= delta_q | pinEdge;
  end

  // interrupt enable and modem control registers
  always @(posedge clk) begin
    if (rst) begin
      ier_q <= `UMH_RST_IER;
      mcr_q <= `UMH_RST_MCR;
    end else if (wrLo) begin
      if (sel == SEL_IER)
        ier_q <= pwdata[7:0];
      if (sel == SEL_MCR)
        mcr_q <= pwdata[`UMH_MCR_W-1:0];
    end
  end

  // sticky event bit and its mask; write one clears, a new event wins
  always @(posedge clk) begin
    if (rst) begin
      evStat_q <= {`UMH_EV_W{1'b0}};
      evMask_q <= {`UMH_EV_W{`UMH_RST_MASK}};
    end else begin
      if (wrLo && sel == SEL_IMASK)
        evMask_q <= pwdata[`UMH_EV_W-1:0];
      if (modemInt)
        evStat_q[`UMH_EV_MODEM] <= 1'b1;
      else if (wrLo && sel == SEL_ISTAT && pwdata[`UMH_EV_MODEM])
        evStat_q[`UMH_EV_MODEM] <= 1'b0;
    end
  end

  // handshake outputs; loopback forces both inactive high
  // clear to send has no path toward the transmitter here
  always @(posedge clk) begin
    if (rst) begin
      terminal_ready_n  <= 1'b1;
      request_to_send_n <= 1'b1;
      loopbackMode      <= 1'b0;
      irq               <= 1'b0;
    end else begin
      terminal_ready_n  <= ~(mcr_q[`UMH_MCR_DTR] & ~mcr_q[`UMH_MCR_LOOP]);
      request_to_send_n <= ~(mcr_q[`UMH_MCR_RTS] & ~mcr_q[`UMH_MCR_LOOP]);
      loopbackMode      <= mcr_q[`UMH_MCR_LOOP];
      irq               <= |(evStat_q & evMask_q);
    end
  end

  // apb answer: ready in the first access-phase cycle, error on unmapped
  always @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (sel == SEL_NONE);
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        if (sel == SEL_IER)
          prdata <= {24'h00_0000, ier_q};
        else if (sel == SEL_MCR)
          prdata <= {27'h000_0000, mcr_q};
        else if (sel == SEL_MSR)
          prdata <= {24'h00_0000, msrValue};
        else if (sel == SEL_ISTAT)
          prdata <= {31'h0000_0000, evStat_q};
        else if (sel == SEL_IMASK)
          prdata <= {31'h0000_0000, evMask_q};
      end
    end
  end

endmodule

// [umh_modem_ctl_assertions.sv]
/* checker for the modem handshake block.
   assumes: bound to umh_modem_ctl; sees only its ports; one clock. */
`timescale 1ns/1ps
`include "umh_map.vh"
module umh_modem_ctl_chk #(
  parameter AW = 12
) (
  input wire          clk,                // clock
  input wire          rst,                // reset
  input wire          psel,               // apb
  input wire          penable,            // apb
  input wire          pwrite,             // apb
  input wire [AW-1:0] paddr,              // apb
  input wire [3:0]    pstrb,              // apb
  input wire [31:0]   pwdata,             // apb
  input wire [31:0]   prdata,             // apb
  input wire          pready,             // apb
  input wire          pslverr,            // apb
  input wire          clear_to_send_n,    // pin
  input wire          data_set_ready_n,   // pin
  input wire          ring_indicator_n,   // pin
  input wire          carrier_detect_n,   // pin
  input wire          terminal_ready_n,   // pin
  input wire          request_to_send_n,  // pin
  input wire          loopbackMode,       // loop
  input wire          irq                 // interrupt
);
  // completed accesses by kind; pins held stable long enough to cross the synchroniser
  wire [3:0] pins  = {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n};
  wire       acc   = psel && penable && pready;
  wire       rdMsr = acc && !pwrite && paddr == `UMH_OFS_MSR;
  wire       mcrWr = acc && pwrite && pstrb[0] && paddr == `UMH_OFS_MCR;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rdy_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_rdy_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_rdy: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_status_levels: assert property (($stable(pins) [*5]) ##0 rdMsr |-> prdata[7:4] == ~pins)
    else $error("status levels wrong");
  a_ctl_follows: assert property (mcrWr && !pwdata[4] |-> ##2 (terminal_ready_n == !$past(pwdata[0], 2) && request_to_send_n == !$past(pwdata[1], 2)))
    else $error("handshake outputs wrong");
  a_loop_quiet: assert property (loopbackMode && $past(loopbackMode) |-> terminal_ready_n && request_to_send_n)
    else $error("output active in loopback");
  a_reset_idle: assert property ($past(rst) |-> terminal_ready_n && request_to_send_n && !irq)
    else $error("outputs not idle after reset");
  a_irq_drop: assert property ($fell(irq) |-> $past(pwrite && penable) || $past(pwrite && penable, 2))
    else $error("irq dropped without a write");
  cover property (rdMsr && prdata[3:0] != 4'h0);
  cover property ($rose(irq));
  cover property (loopbackMode && mcrWr);
endmodule
bind umh_modem_ctl umh_modem_ctl_chk #(.AW(AW)) chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .clear_to_send_n(clear_to_send_n),
  .data_set_ready_n(data_set_ready_n), .ring_indicator_n(ring_indicator_n),
  .carrier_detect_n(carrier_detect_n), .terminal_ready_n(terminal_ready_n),
  .request_to_send_n(request_to_send_n), .loopbackMode(loopbackMode), .irq(irq));

// [umh_modem_model.sv]
/* modem stand-in: drives the four low-active status pins.
   assumes: the bench calls setPins; lines idle high like an unplugged modem. */
`timescale 1ns/1ps
module umh_modem_model (
  input  wire       clk,  // system clock
  output reg  [3:0] pins  // {dcd, ri, dsr, cts}
);
  // idle level before any command, so no change shows at start
  initial pins = 4'hf;
  // changes land just after an edge, never on it
  task setPins(input [3:0] v);
    @(posedge clk);
    pins <= v;
  endtask
endmodule

// [umh_sync2.v]
/*
  umh_sync2.v: two-flop synchroniser for a group of level inputs.
  assumes: inputs are asynchronous to clk; only the second stage is read.
*/
`timescale 1ns/1ps
module umh_sync2 #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input  wire             clk,    // system clock
  input  wire             rst,    // synchronous reset, active high
  input  wire [WIDTH-1:0] async,  // raw pin levels
  output reg  [WIDTH-1:0] syncQ   // synchronised levels
);

  reg [WIDTH-1:0] meta_q;

  // first stage feeds only the second; reset to idle pin level
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      syncQ  <= RST_VAL;
    end else begin
      meta_q <= async;
      syncQ  <= meta_q;
    end
  end

endmodule
